// File: rtl/qadc_pkg.sv
package qadc_pkg;
	// Timing
	localparam int CLK_MHZ = 10;
	localparam int WAKE_SLOW_US = 100;
	localparam int WAKE_FAST_US = 10;
	localparam int WAKE_SLOW_CYC = WAKE_SLOW_US * CLK_MHZ;
	localparam int WAKE_FAST_CYC = WAKE_FAST_US * CLK_MHZ;
	localparam int FAST_OVR_LAT = 7;
	// Register indices, byte address is four times the index
	localparam logic [7:0] IDX_CH_B = 8'h25;
	localparam logic [7:0] IDX_CH_A = 8'h2B;
	localparam logic [7:0] IDX_CH_D = 8'h31;
	localparam logic [7:0] IDX_CH_C = 8'h37;
	localparam logic [7:0] IDX_FIX = 8'h3D;
	localparam logic [7:0] IDX_WORD_HI = 8'h3F;
	localparam logic [7:0] IDX_WORD_LO = 8'h40;
	localparam logic [7:0] IDX_FEAT = 8'h42;
	localparam logic [7:0] IDX_OVP = 8'h45;
	localparam logic [7:0] IDX_SLOW_A = 8'h4A;
	localparam logic [7:0] IDX_SLOW_B = 8'h62;
	localparam logic [7:0] IDX_SLOW_D = 8'h7A;
	localparam logic [7:0] IDX_SLOW_C = 8'h92;
	localparam logic [7:0] IDX_FIX2 = 8'hCF;
	localparam logic [7:0] RST_VAL = 8'h00;
	// Field positions
	localparam int SKIP_BIT = 3;
	localparam int FIX1_BIT = 5;
	localparam int FIX2_BIT = 3;
	localparam int FEAT_BIT = 3;
	localparam int LSBOFF_BIT = 4;
	localparam int KIND_BIT = 3;
	localparam int GPD_BIT = 2;
	localparam int ROLE_BIT = 0;
	localparam int SLOW_BIT = 0;
	// Data constants
	localparam logic [13:0] MID_CODE = 14'h1FFF;
	localparam logic [13:0] TOGGLE_A = 14'h1555;
	localparam logic [13:0] TOGGLE_B = 14'h2AAA;
	localparam logic [13:0] FULL_CODE = 14'h3FFF;
	localparam logic [3:0] GAIN_MAX = 4'hC;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		PAT_DATA = 3'h0,
		PAT_ZERO = 3'h1,
		PAT_ONE = 3'h2,
		PAT_TOGGLE = 3'h3,
		PAT_RAMP = 3'h4,
		PAT_USER = 3'h5
	} qadc_pattern_t;
	typedef enum logic [2:0] {
		PW_DOWN = 3'b001,
		PW_WAKE = 3'b010,
		PW_RUN = 3'b100
	} qadc_power_t;
endpackage

// File: rtl/qadc_digital_config.sv
`timescale 1ns/1ps
module qadc_digital_config (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Converter side
	input wire logic sample_valid,
	input wire logic [3:0][13:0] adc_data,
	input wire logic [3:0] overload_fast,
	input wire logic [3:0] overload_normal,
	input wire logic shutdown_pin,
	// Receiver side
	output logic out_valid,
	output logic [3:0][13:0] out_data,
	output logic [3:0] overrange_flag,
	output logic [3:0] slow_rate_mode,
	output logic global_down,
	output logic standby
);

	////////////////////////////////////////////////////////////////////////
	logic [7:0] ch_cfg [4];
	logic fix1, fix2, feat, lsb_off, kind, gpd, role;
	logic [13:0] word;
	logic aw_hit;
	logic [7:0] aw_idx;
	logic [7:0] wd;
	qadc_pkg::qadc_power_t pstate;
	logic [9:0] wake_cnt;
	logic slow_wake;
	logic down_req, stby_req, run;
	logic [13:0] ramp;
	logic tog;
	logic [3:0][6:0] fast_sh;
	logic signed [21:0] dc [4];
	logic [3:0][13:0] proc;
	logic [3:0] flag_sel;

	function automatic logic mapped(input logic [11:0] a);
		logic [7:0] i;
		i = a[9:2];
		mapped = a[11:10] == 2'h0 && (i == qadc_pkg::IDX_CH_A || i == qadc_pkg::IDX_CH_B
			|| i == qadc_pkg::IDX_CH_C || i == qadc_pkg::IDX_CH_D || i == qadc_pkg::IDX_FIX
			|| i == qadc_pkg::IDX_WORD_HI || i == qadc_pkg::IDX_WORD_LO
			|| i == qadc_pkg::IDX_FEAT || i == qadc_pkg::IDX_OVP || i == qadc_pkg::IDX_FIX2
			|| i == qadc_pkg::IDX_SLOW_A || i == qadc_pkg::IDX_SLOW_B
			|| i == qadc_pkg::IDX_SLOW_C || i == qadc_pkg::IDX_SLOW_D);
	endfunction

	function automatic logic [7:0] read_reg(input logic [7:0] i);
		case (i)
			qadc_pkg::IDX_CH_A: read_reg = ch_cfg[0];
			qadc_pkg::IDX_CH_B: read_reg = ch_cfg[1];
			qadc_pkg::IDX_CH_C: read_reg = ch_cfg[2];
			qadc_pkg::IDX_CH_D: read_reg = ch_cfg[3];
			qadc_pkg::IDX_FIX: read_reg = 8'(fix1) << qadc_pkg::FIX1_BIT;
			qadc_pkg::IDX_WORD_HI: read_reg = {2'h0, word[13:8]};
			qadc_pkg::IDX_WORD_LO: read_reg = word[7:0];
			qadc_pkg::IDX_FEAT: read_reg = 8'(feat) << qadc_pkg::FEAT_BIT;
			qadc_pkg::IDX_OVP: read_reg = (8'(lsb_off) << qadc_pkg::LSBOFF_BIT)
				| (8'(kind) << qadc_pkg::KIND_BIT) | (8'(gpd) << qadc_pkg::GPD_BIT)
				| (8'(role) << qadc_pkg::ROLE_BIT);
			qadc_pkg::IDX_FIX2: read_reg = 8'(fix2) << qadc_pkg::FIX2_BIT;
			qadc_pkg::IDX_SLOW_A: read_reg = {7'h00, slow_rate_mode[0]};
			qadc_pkg::IDX_SLOW_B: read_reg = {7'h00, slow_rate_mode[1]};
			qadc_pkg::IDX_SLOW_C: read_reg = {7'h00, slow_rate_mode[2]};
			qadc_pkg::IDX_SLOW_D: read_reg = {7'h00, slow_rate_mode[3]};
			default: read_reg = 8'h00;
		endcase
	endfunction

	// Gain factor, 4096 is unity; codes above the top step clamp to 6 dB
	function automatic logic [13:0] gain_q12(input logic [3:0] g);
		case (g)
			4'h0: gain_q12 = 14'h1000;
			4'h1: gain_q12 = 14'h10F3;
			4'h2: gain_q12 = 14'h11F4;
			4'h3: gain_q12 = 14'h1304;
			4'h4: gain_q12 = 14'h1425;
			4'h5: gain_q12 = 14'h1557;
			4'h6: gain_q12 = 14'h169A;
			4'h7: gain_q12 = 14'h17F1;
			4'h8: gain_q12 = 14'h195C;
			4'h9: gain_q12 = 14'h1ADD;
			4'hA: gain_q12 = 14'h1C74;
			4'hB: gain_q12 = 14'h1E24;
			default: gain_q12 = 14'h1FED;
		endcase
	endfunction

	function automatic logic [13:0] sat14(input logic signed [31:0] v);
		if (v < 0)
			sat14 = 14'h0000;
		else if (v > 32'sd16383)
			sat14 = qadc_pkg::FULL_CODE;
		else
			sat14 = v[13:0];
	endfunction

	// Gain is applied about mid-scale so the centre code stays put
	function automatic logic [13:0] apply_gain(input logic [13:0] x, input logic [3:0] g);
		logic signed [31:0] s;
		s = $signed({18'h0, x}) - 32'sd8192;
		s = (s * $signed({18'h0, gain_q12(g)})) >>> 12;
		apply_gain = sat14(s + 32'sd8192);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write: address and data taken in either order
	assign aw_hit = mapped(awaddr);
	assign wd = wdata[7:0];
	logic [7:0] hold_idx;
	logic hold_hit, hold_strb;
	logic [7:0] hold_data;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= qadc_pkg::RESP_OKAY;
			hold_idx <= 8'h00;
			hold_hit <= 1'b0;
			hold_strb <= 1'b0;
			hold_data <= 8'h00;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				hold_idx <= awaddr[9:2];
				hold_hit <= aw_hit;
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				hold_data <= wd;
				hold_strb <= wstrb[0];
			end
			if (!awready && !wready && !bvalid) begin
				bvalid <= 1'b1;
				bresp <= hold_hit ? qadc_pkg::RESP_OKAY : qadc_pkg::RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	assign aw_idx = hold_idx;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int c = 0; c < 4; c++)
				ch_cfg[c] <= qadc_pkg::RST_VAL;
			{fix1, fix2, feat, lsb_off, kind, gpd, role} <= 7'h00;
			word <= 14'h0000;
			slow_rate_mode <= 4'h0;
		end else if (!awready && !wready && !bvalid && hold_hit && hold_strb) begin
			case (aw_idx)
				qadc_pkg::IDX_CH_A: ch_cfg[0] <= hold_data;
				qadc_pkg::IDX_CH_B: ch_cfg[1] <= hold_data;
				qadc_pkg::IDX_CH_C: ch_cfg[2] <= hold_data;
				qadc_pkg::IDX_CH_D: ch_cfg[3] <= hold_data;
				qadc_pkg::IDX_FIX: fix1 <= hold_data[qadc_pkg::FIX1_BIT];
				qadc_pkg::IDX_WORD_HI: word[13:8] <= hold_data[5:0];
				qadc_pkg::IDX_WORD_LO: word[7:0] <= hold_data;
				qadc_pkg::IDX_FEAT: feat <= hold_data[qadc_pkg::FEAT_BIT];
				qadc_pkg::IDX_OVP: begin
					lsb_off <= hold_data[qadc_pkg::LSBOFF_BIT];
					kind <= hold_data[qadc_pkg::KIND_BIT];
					gpd <= hold_data[qadc_pkg::GPD_BIT];
					role <= hold_data[qadc_pkg::ROLE_BIT];
				end
				qadc_pkg::IDX_FIX2: fix2 <= hold_data[qadc_pkg::FIX2_BIT];
				qadc_pkg::IDX_SLOW_A: slow_rate_mode[0] <= hold_data[qadc_pkg::SLOW_BIT];
				qadc_pkg::IDX_SLOW_B: slow_rate_mode[1] <= hold_data[qadc_pkg::SLOW_BIT];
				qadc_pkg::IDX_SLOW_C: slow_rate_mode[2] <= hold_data[qadc_pkg::SLOW_BIT];
				qadc_pkg::IDX_SLOW_D: slow_rate_mode[3] <= hold_data[qadc_pkg::SLOW_BIT];
				default: ;
			endcase
		end
	end

	// AXI4-Lite read, answered one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= qadc_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= {24'h000000, read_reg(araddr[9:2])};
			rresp <= mapped(araddr) ? qadc_pkg::RESP_OKAY : qadc_pkg::RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power sequencing
	assign down_req = gpd || (shutdown_pin && role);
	assign stby_req = shutdown_pin && !role;
	assign run = pstate == qadc_pkg::PW_RUN;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pstate <= qadc_pkg::PW_RUN;
			wake_cnt <= 10'h000;
			slow_wake <= 1'b0;
			global_down <= 1'b0;
			standby <= 1'b0;
		end else begin
			global_down <= down_req;
			standby <= stby_req;
			case (pstate)
				qadc_pkg::PW_RUN: begin
					if (down_req || stby_req) begin
						pstate <= qadc_pkg::PW_DOWN;
						slow_wake <= down_req;
					end
				end
				qadc_pkg::PW_DOWN: begin
					if (down_req)
						slow_wake <= 1'b1;
					if (!down_req && !stby_req) begin
						pstate <= qadc_pkg::PW_WAKE;
						wake_cnt <= slow_wake ? 10'(qadc_pkg::WAKE_SLOW_CYC)
							: 10'(qadc_pkg::WAKE_FAST_CYC);
					end
				end
				qadc_pkg::PW_WAKE: begin
					if (down_req || stby_req) begin
						pstate <= qadc_pkg::PW_DOWN;
						slow_wake <= down_req;
					end else if (wake_cnt == 10'h001) begin
						pstate <= qadc_pkg::PW_RUN;
					end else begin
						wake_cnt <= wake_cnt - 10'h001;
					end
				end
				default: pstate <= qadc_pkg::PW_DOWN;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shared pattern state and per-channel trackers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ramp <= 14'h0000;
			tog <= 1'b0;
			fast_sh <= '0;
			for (int c = 0; c < 4; c++)
				dc[c] <= 22'sd0;
		end else if (sample_valid) begin
			ramp <= ramp + 14'h0001;
			tog <= !tog;
			for (int c = 0; c < 4; c++) begin
				fast_sh[c] <= {fast_sh[c][5:0], overload_fast[c]};
				dc[c] <= dc[c] + ($signed({8'h00, adc_data[c]}) - 22'sd8191)
					- (dc[c] >>> 8);
			end
		end
	end

	always_comb begin
		for (int c = 0; c < 4; c++) begin
			proc[c] = adc_data[c];
			if (feat && fix1)
				proc[c] = sat14(32'($signed({1'b0, adc_data[c]})) - 32'(dc[c] >>> 8));
			if (feat && !ch_cfg[c][qadc_pkg::SKIP_BIT])
				proc[c] = apply_gain(proc[c], ch_cfg[c][7:4]);
			flag_sel[c] = kind ? overload_normal[c] : fast_sh[c][6];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_valid <= 1'b0;
			out_data <= '0;
			overrange_flag <= 4'h0;
		end else if (!run) begin
			out_valid <= 1'b0;
			out_data <= '0;
			overrange_flag <= 4'h0;
		end else begin
			out_valid <= sample_valid;
			if (sample_valid) begin
				for (int c = 0; c < 4; c++) begin
					overrange_flag[c] <= flag_sel[c];
					case (ch_cfg[c][2:0])
						qadc_pkg::PAT_DATA: out_data[c] <= lsb_off ? proc[c]
							: {proc[c][13:1], flag_sel[c]};
						qadc_pkg::PAT_ZERO: out_data[c] <= 14'h0000;
						qadc_pkg::PAT_ONE: out_data[c] <= qadc_pkg::FULL_CODE;
						qadc_pkg::PAT_TOGGLE: out_data[c] <= tog ? qadc_pkg::TOGGLE_B
							: qadc_pkg::TOGGLE_A;
						qadc_pkg::PAT_RAMP: out_data[c] <= ramp;
						qadc_pkg::PAT_USER: out_data[c] <= word;
						default: out_data[c] <= 14'h0000;
					endcase
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	chk_zero_pattern: assert property (@(posedge aclk) disable iff (!aresetn)
		run && sample_valid && ch_cfg[0][2:0] == 3'h1 |=> out_data[0] == 14'h0000)
		else $error("all-zero pattern wrong");
	chk_toggle_alt: assert property (@(posedge aclk) disable iff (!aresetn)
		run && sample_valid && ch_cfg[0][2:0] == 3'h3 ##1 run && sample_valid
		&& ch_cfg[0][2:0] == 3'h3 |=> out_data[0] == ~$past(out_data[0]))
		else $error("toggle pattern does not alternate");
	chk_ramp_step: assert property (@(posedge aclk) disable iff (!aresetn)
		sample_valid |=> ramp == 14'($past(ramp) + 14'h0001))
		else $error("ramp did not step");
	chk_user_word: assert property (@(posedge aclk) disable iff (!aresetn)
		run && sample_valid && ch_cfg[0][2:0] == 3'h5 |=> out_data[0] == $past(word))
		else $error("user word not shown");
	chk_gain_off: assert property (@(posedge aclk) disable iff (!aresetn)
		run && sample_valid && ch_cfg[0][2:0] == 3'h0 && lsb_off
		&& (!feat || (ch_cfg[0][3] && !fix1)) |=> out_data[0] == $past(adc_data[0]))
		else $error("data altered with gain off");
	chk_lsb_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		run && sample_valid && ch_cfg[0][2:0] == 3'h0 && !lsb_off
		|=> out_data[0][0] == overrange_flag[0])
		else $error("overrange flag not on LSB");
	chk_fast_delay: assert property (@(posedge aclk) disable iff (!aresetn)
		sample_valid && overload_fast[0] ##1 (sample_valid && run && !kind)[*7]
		|=> overrange_flag[0])
		else $error("fast overrange latency wrong");
	chk_down_stop: assert property (@(posedge aclk) disable iff (!aresetn)
		gpd |=> !run && global_down ##1 !out_valid)
		else $error("global power down ignored");
	chk_wake_slow: assert property (@(posedge aclk) disable iff (!aresetn)
		pstate == qadc_pkg::PW_DOWN && slow_wake && !down_req && !stby_req
		|=> !run [*8])
		else $error("slow wake too short");

endmodule

// File: testbench/qadc_rx.sv
`timescale 1ns/1ps
module qadc_rx (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Sample stream from the converter block
	input wire logic out_valid,
	input wire logic [13:0] out_data,
	// Captured view
	output logic [13:0] cap_data,
	output logic [31:0] cap_count
);
	// Capture only on valid, as a real receiver would
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cap_data <= 14'h0000;
			cap_count <= 32'h0000_0000;
		end else if (out_valid) begin
			cap_data <= out_data;
			cap_count <= cap_count + 32'h0000_0001;
		end
	end
endmodule

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic sample_valid = 1'h0, shutdown_pin = 1'h0;
	logic [3:0][13:0] adc_data = '0;
	logic [3:0][13:0] d;
	logic [3:0] ovf = 4'h0, ovn = 4'h0;
	logic out_valid, global_down, standby;
	logic [3:0][13:0] out_data;
	logic [3:0] overrange_flag, slow_rate_mode;
	logic [13:0] cap, v, x;
	logic [7:0] m;
	int n_fail = 0, total_checks = 0, cyc = 0;
	logic [31:0] lf = 32'hA9A5;
	logic [7:0] chi [4] = '{qadc_pkg::IDX_CH_A, qadc_pkg::IDX_CH_B, qadc_pkg::IDX_CH_C,
		qadc_pkg::IDX_CH_D};
	logic [7:0] regs [14] = '{8'h25, 8'h2B, 8'h31, 8'h37, 8'h3D, 8'h3F, 8'h40, 8'h42, 8'h45,
		8'h4A, 8'h62, 8'h7A, 8'h92, 8'hCF};

	always #50 aclk = ~aclk;

	qadc_digital_config i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .sample_valid(sample_valid), .adc_data(adc_data),
		.overload_fast(ovf), .overload_normal(ovn), .shutdown_pin(shutdown_pin),
		.out_valid(out_valid), .out_data(out_data), .overrange_flag(overrange_flag),
		.slow_rate_mode(slow_rate_mode), .global_down(global_down), .standby(standby));
	qadc_rx i_rx (.aclk(aclk), .aresetn(aresetn), .out_valid(out_valid),
		.out_data(out_data[0]), .cap_data(cap), .cap_count());

	////////////////////////////////////////////////////////////////////////////////
	task rnd;
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
	endtask
	function int gexp(input int xi, input int c);
		real r;
		r = 8192.0 + (xi - 8192) * (10.0 ** (c / 40.0));
		return int'(r);
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task chkn(input logic [13:0] got, input int exp, input int tol);
		total_checks++;
		if ($isunknown(got) || int'(got) > exp + tol || int'(got) < exp - tol) begin
			n_fail++;
			$display("wrong value at %0t: got %0d near %0d", $time, got, exp);
		end
	endtask
	task final_report;
		$display("checks %0d errors %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task step(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Bus master: hold each channel until its own ready, response after both
	task wr(input logic [7:0] i, input logic [7:0] dv, input logic [1:0] er = 2'h0);
		@(posedge aclk);
		awaddr <= {2'h0, i, 2'h0};
		wdata <= {24'h0, dv};
		wstrb <= 4'hF;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		bready <= 1'h0;
		chk(32'(bresp), 32'(er));
	endtask
	task rd(input logic [7:0] i, input logic [7:0] e, input logic [1:0] er = 2'h0);
		@(posedge aclk);
		araddr <= {2'h0, i, 2'h0};
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		rready <= 1'h0;
		chk(rdata, {24'h0, e});
		chk(32'(rresp), 32'(er));
	endtask
	task allch(input logic [7:0] val);
		for (int c = 0; c < 4; c++) wr(chi[c], val);
	endtask
	task wake(input int n);
		step(n - 100);
		chk(32'(out_valid), 32'h0);
		step(200);
		chk(32'(out_valid), 32'h1);
	endtask

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			$display("wrong value at %0t: run too long", $time);
			final_report;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		sample_valid <= 1'h1;
		foreach (regs[k]) rd(regs[k], qadc_pkg::RST_VAL);
		rd(8'h26, 8'h00, qadc_pkg::RESP_SLVERR);
		wr(8'h26, 8'h55, qadc_pkg::RESP_SLVERR);
		// Shared user word, then pattern codes 1 to 4 and 6
		rnd;
		wr(qadc_pkg::IDX_WORD_HI, {2'h0, lf[13:8]});
		wr(qadc_pkg::IDX_WORD_LO, lf[7:0]);
		rd(qadc_pkg::IDX_WORD_HI, {2'h0, lf[13:8]});
		allch(8'h05);
		step(2);
		for (int c = 0; c < 4; c++) chk(32'(out_data[c]), 32'(lf[13:0]));
		allch(8'h01);
		step(2);
		for (int c = 0; c < 4; c++) chk(32'(out_data[c]), 32'h0);
		allch(8'h02);
		step(2);
		for (int c = 0; c < 4; c++) chk(32'(out_data[c]), 32'(qadc_pkg::FULL_CODE));
		allch(8'h06);
		step(2);
		chk(32'(out_data[2]), 32'h0);
		allch(8'h03);
		step(2);
		v = out_data[0];
		chk(32'(v === qadc_pkg::TOGGLE_A || v === qadc_pkg::TOGGLE_B), 32'h1);
		step(1);
		for (int c = 0; c < 4; c++) chk(32'(out_data[c] ^ v), 32'h3FFF);
		allch(8'h04);
		step(3);
		for (int k = 0; k < 16390; k++) begin
			v = cap;
			step(1);
			chk(32'(cap), 32'(14'(v + 14'h1)));
		end
		chk(32'(out_data[3]), 32'(out_data[0]));
		// Raw path with random samples, flag on the LSB and beside it
		allch(8'h00);
		for (int j = 0; j < 2; j++) begin
			m = j ? 8'h08 : 8'h18;
			wr(qadc_pkg::IDX_OVP, m);
			for (int k = 0; k < 8; k++) begin
				@(posedge aclk);
				rnd;
				d[1:0] = lf[27:0];
				ovn <= lf[31:28];
				rnd;
				d[3:2] = lf[27:0];
				adc_data <= d;
				@(posedge aclk);
				#1;
				for (int c = 0; c < 4; c++)
					chk(32'(out_data[c]), 32'(m[4] ? d[c] : {d[c][13:1], ovn[c]}));
				chk(32'(overrange_flag), 32'(ovn));
			end
		end
		// Fast indication lags the overload by seven samples
		wr(qadc_pkg::IDX_OVP, 8'h00);
		ovn <= 4'h0;
		@(posedge aclk);
		ovf <= 4'h1;
		@(posedge aclk);
		ovf <= 4'h0;
		step(6);
		chk(32'(overrange_flag[0]), 32'h0);
		step(1);
		chk(32'(overrange_flag[0]), 32'h1);
		chk(32'(out_data[0][0]), 32'h1);
		// Gain sweep about mid-scale
		rnd;
		x = 14'(6000 + lf[11:0]);
		adc_data <= {4{x}};
		wr(qadc_pkg::IDX_OVP, 8'h10);
		allch(8'hC0);
		step(3);
		chk(32'(out_data[1]), 32'(x));
		wr(qadc_pkg::IDX_FEAT, 8'h08);
		for (int g = 0; g < 13; g++) begin
			allch({4'(g), 4'h0});
			step(3);
			for (int c = 0; c < 4; c++) chkn(out_data[c], gexp(x, g), 2);
		end
		allch(8'hC8);
		step(3);
		chk(32'(out_data[0]), 32'(x));
		// Mid-code correction
		allch(8'h00);
		wr(qadc_pkg::IDX_FIX, 8'h20);
		wr(qadc_pkg::IDX_FIX2, 8'h08);
		step(4000);
		for (int c = 0; c < 4; c++) chkn(out_data[c], 8191, 4);
		wr(qadc_pkg::IDX_FIX, 8'h00);
		wr(qadc_pkg::IDX_SLOW_A, 8'h01);
		wr(qadc_pkg::IDX_SLOW_C, 8'h01);
		step(2);
		chk(32'(slow_rate_mode), 32'h5);
		// Power states and the pin role
		wr(qadc_pkg::IDX_OVP, 8'h14);
		step(2);
		chk(32'(global_down), 32'h1);
		chk(32'(out_data[0]), 32'h0);
		wr(qadc_pkg::IDX_OVP, 8'h10);
		wake(qadc_pkg::WAKE_SLOW_CYC);
		shutdown_pin <= 1'h1;
		step(2);
		chk(32'({standby, global_down}), 32'h2);
		shutdown_pin <= 1'h0;
		wake(qadc_pkg::WAKE_FAST_CYC);
		wr(qadc_pkg::IDX_OVP, 8'h11);
		shutdown_pin <= 1'h1;
		step(2);
		chk(32'({standby, global_down}), 32'h1);
		shutdown_pin <= 1'h0;
		wake(qadc_pkg::WAKE_SLOW_CYC);
		final_report;
	end
endmodule
